// ==== rtl/fogp_fail_gpio.sv ====
// Fail-output and GPIO pin control with its APB register pair.
// Assumes SBC mode, failure event and failure condition come from the supervisor, synchronous.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module fogp_fail_gpio
#(
  parameter int STRAP_CYCLES = fogp_pkg::STRAP_CYCLES,
  parameter int IND_CYCLES   = fogp_pkg::IND_CYCLES,
  parameter int PL_CYCLES    = fogp_pkg::PL_CYCLES
)
(
  input  wire logic                 CLOCK,
  input  wire logic                 RST_N,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [7:0]           PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic [31:0]               PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  input  wire fogp_pkg::fogp_mode_t SBC_MODE,
  input  wire logic                 FAIL_EVT,
  input  wire logic                 FAIL_COND,
  output logic                      STATIC_FAIL_OUT_O,
  output logic                      STATIC_FAIL_OUT_OE,
  input  wire logic                 INDICATOR_FAIL_OUT_I,
  output logic                      INDICATOR_FAIL_OUT_O,
  output logic                      INDICATOR_FAIL_OUT_OE,
  output logic                      INDICATOR_WAKE_EN,
  input  wire logic                 PULSED_FAIL_OUT_STRAP_I,
  output logic                      PULSED_FAIL_OUT_STRAP_O,
  output logic                      PULSED_FAIL_OUT_STRAP_OE,
  output logic                      PULSED_WAKE_EN,
  output logic                      DEV_MODE_STRAP
);

  localparam int CW = fogp_pkg::CNT_W;

  // Configuration state
  fogp_pkg::fogp_pincfg_t cfg2_r;
  fogp_pkg::fogp_pincfg_t cfg3_r;
  logic [1:0]             duty_r;
  logic                   fo_on_r;
  logic                   fail_r;
  logic                   fail_nxt;

  // Waveform and filter state
  logic [CW-1:0]          ind_cnt_r;
  logic                   ind_ph_r;
  logic [CW-1:0]          pl_cnt_r;
  logic [CW-1:0]          strap_cnt_r;
  logic                   strap_r;
  logic                   static_oe_r;
  logic [31:0]            rdata_r;

  fogp_pkg::fogp_drv_t    drv2;
  fogp_pkg::fogp_drv_t    drv3;

  // APB decode
  wire logic              acc;
  wire logic              hit_ctrl;
  wire logic              hit_stat;
  wire logic              wr_ctrl;
  wire logic              wr_stat;
  wire logic              rd_any;
  wire logic              in_normal;
  wire logic              fail_on;
  wire logic              fail_clr;
  wire logic              ind_end;
  wire logic              pl_end;
  wire logic              pl_low;
  wire logic              strap_diff;
  wire logic              strap_take;
  wire logic [CW-1:0]     duty_cyc;
  wire logic [31:0]       ctrl_rd;
  wire logic [31:0]       stat_rd;

  assign acc       = PSEL && PENABLE;
  assign hit_ctrl  = PADDR == fogp_pkg::CTRL_OFS;
  assign hit_stat  = PADDR == fogp_pkg::STAT_OFS;
  assign in_normal = SBC_MODE == fogp_pkg::MODE_NORMAL;
  // Writes outside Normal complete on the bus but change nothing
  assign wr_ctrl   = acc && PWRITE && hit_ctrl && in_normal;
  assign wr_stat   = acc && PWRITE && hit_stat;
  // Read word loaded in the setup cycle so it stands at the access edge
  assign rd_any    = PSEL && !PENABLE && !PWRITE;

  assign PREADY    = 1'b1;
  assign PSLVERR   = acc && !(hit_ctrl || hit_stat);
  assign PRDATA    = rdata_r;

  assign ctrl_rd = {15'h0000, fo_on_r, 2'h0, duty_r, 2'h0, cfg3_r.sw_on, cfg2_r.sw_on,
                    1'b0, cfg3_r.func, 1'b0, cfg2_r.func};
  assign stat_rd = {21'h000000, SBC_MODE, 3'h0, PULSED_FAIL_OUT_STRAP_I,
                    INDICATOR_FAIL_OUT_I, DEV_MODE_STRAP, fo_on_r, fail_r};

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      rdata_r <= 32'h00000000;
    else if (rd_any)
      rdata_r <= hit_ctrl ? ctrl_rd : (hit_stat ? stat_rd : 32'h00000000);
  end

  // Configuration only moves in Normal; Stop/Sleep/Restart keep it untouched
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cfg2_r  <= '{func: fogp_pkg::FUNC_RST, sw_on: 1'b0};
      cfg3_r  <= '{func: fogp_pkg::FUNC_RST, sw_on: 1'b0};
      duty_r  <= fogp_pkg::DUTY_RST;
      fo_on_r <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      cfg2_r.func  <= fogp_pkg::fogp_func_t'(PWDATA[fogp_pkg::CTRL_F2_LSB +: 3]);
      cfg3_r.func  <= fogp_pkg::fogp_func_t'(PWDATA[fogp_pkg::CTRL_F3_LSB +: 3]);
      cfg2_r.sw_on <= PWDATA[fogp_pkg::CTRL_SW2_BIT];
      cfg3_r.sw_on <= PWDATA[fogp_pkg::CTRL_SW3_BIT];
      duty_r       <= PWDATA[fogp_pkg::CTRL_DC_LSB +: 2];
      fo_on_r      <= PWDATA[fogp_pkg::CTRL_FOON_BIT];
    end
  end

  // Failure latch: a new event beats a clear in the same cycle
  assign fail_clr = wr_stat && PWDATA[fogp_pkg::STAT_FAIL_BIT] && in_normal && !FAIL_COND;
  assign fail_nxt = FAIL_EVT || FAIL_COND || (fail_r && !fail_clr);
  assign fail_on  = fail_r || fo_on_r;

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      fail_r <= 1'b0;
    else
      fail_r <= fail_nxt;
  end

  // Indicator: starts in the pulled-low half so the lamp lights at once
  assign ind_end = ind_cnt_r == CW'(IND_CYCLES - 1);

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ind_cnt_r <= '0;
      ind_ph_r  <= 1'b1;
    end
    else if (!fail_on)
    begin
      ind_cnt_r <= '0;
      ind_ph_r  <= 1'b1;
    end
    else
    begin
      ind_cnt_r <= ind_end ? '0 : ind_cnt_r + 1'b1;
      ind_ph_r  <= ind_end ? !ind_ph_r : ind_ph_r;
    end
  end

  // Pulsed light: low for the selected share of each period
  assign duty_cyc = CW'(fogp_pkg::fogp_duty_cycles(duty_r, PL_CYCLES));
  assign pl_end   = pl_cnt_r == CW'(PL_CYCLES - 1);
  assign pl_low   = pl_cnt_r < duty_cyc;

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      pl_cnt_r <= '0;
    else if (!fail_on || pl_end)
      pl_cnt_r <= '0;
    else
      pl_cnt_r <= pl_cnt_r + 1'b1;
  end

  // Strap filter; level resets high so an undriven pin reads as user mode
  assign strap_diff = PULSED_FAIL_OUT_STRAP_I != strap_r;
  assign strap_take = strap_diff && (strap_cnt_r == CW'(STRAP_CYCLES - 1));

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      strap_cnt_r <= '0;
      strap_r     <= 1'b1;
    end
    else
    begin
      strap_cnt_r <= (strap_diff && !strap_take) ? strap_cnt_r + 1'b1 : '0;
      strap_r     <= strap_take ? PULSED_FAIL_OUT_STRAP_I : strap_r;
    end
  end

  assign DEV_MODE_STRAP = !strap_r;

  // Static output, one register stage to line up with the pin modules
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      static_oe_r <= 1'b0;
    else
      static_oe_r <= fail_on;
  end

  fogp_pin_ctl u_pin2
  (
    .clk       (CLOCK),
    .rst_n     (RST_N),
    .mode      (SBC_MODE),
    .cfg       (cfg2_r),
    .fail_wave (fail_on && ind_ph_r),
    .drv_r     (drv2)
  );

  fogp_pin_ctl u_pin3
  (
    .clk       (CLOCK),
    .rst_n     (RST_N),
    .mode      (SBC_MODE),
    .cfg       (cfg3_r),
    .fail_wave (fail_on && pl_low),
    .drv_r     (drv3)
  );

  // Open drain: fail drive is always low with the enable carrying the state
  assign STATIC_FAIL_OUT_O        = 1'b0;
  assign STATIC_FAIL_OUT_OE       = static_oe_r;
  assign INDICATOR_FAIL_OUT_O     = drv2.o;
  assign INDICATOR_FAIL_OUT_OE    = drv2.oe;
  assign INDICATOR_WAKE_EN        = drv2.wake_en;
  assign PULSED_FAIL_OUT_STRAP_O  = drv3.o;
  assign PULSED_FAIL_OUT_STRAP_OE = drv3.oe;
  assign PULSED_WAKE_EN           = drv3.wake_en;

  a_cfg_write_normal: assert property (@(posedge CLOCK) disable iff (!RST_N)
    acc && PWRITE && hit_ctrl && in_normal
    |=> duty_r == $past(PWDATA[fogp_pkg::CTRL_DC_LSB +: 2]))
    else $error("control write in Normal not taken");
  a_cfg_frozen: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !in_normal |=> $stable(cfg2_r) && $stable(cfg3_r) && $stable(duty_r))
    else $error("configuration changed outside Normal");
  a_fail_event_set: assert property (@(posedge CLOCK) disable iff (!RST_N)
    FAIL_EVT |=> fail_r ##1 STATIC_FAIL_OUT_OE)
    else $error("failure did not activate outputs");
  a_fail_held_restart: assert property (@(posedge CLOCK) disable iff (!RST_N)
    fail_r && (SBC_MODE inside {fogp_pkg::MODE_RESTART, fogp_pkg::MODE_FAILSAFE})
    |=> fail_r)
    else $error("fail latch dropped in restart or fail-safe");
  a_fail_clear_normal: assert property (@(posedge CLOCK) disable iff (!RST_N)
    $fell(fail_r) |-> $past(in_normal && wr_stat && !FAIL_COND && !FAIL_EVT))
    else $error("fail latch cleared without a Normal-mode clear");
  a_outputs_together: assert property (@(posedge CLOCK) disable iff (!RST_N)
    $rose(fail_on) && (cfg2_r.func == fogp_pkg::FUNC_FAIL) && $stable(cfg2_r)
    |=> STATIC_FAIL_OUT_OE && INDICATOR_FAIL_OUT_OE && !INDICATOR_FAIL_OUT_O)
    else $error("fail outputs not activated together");
  a_ind_half_period: assert property (@(posedge CLOCK) disable iff (!RST_N)
    fail_on && $past(fail_on) && $changed(ind_ph_r)
    |-> $past(ind_cnt_r) == CW'(IND_CYCLES - 1))
    else $error("indicator toggled off its half period");
  a_pulse_low_share: assert property (@(posedge CLOCK) disable iff (!RST_N)
    fail_on && (duty_r == 2'h0) && (pl_cnt_r == CW'(PL_CYCLES / 5))
    |-> !pl_low && $past(pl_low))
    else $error("pulsed-light duty edge misplaced");
  a_strap_stable: assert property (@(posedge CLOCK) disable iff (!RST_N)
    $changed(strap_r) |-> $past(strap_cnt_r) == CW'(STRAP_CYCLES - 1))
    else $error("strap accepted before filter time");
  a_unmapped_err: assert property (@(posedge CLOCK) disable iff (!RST_N)
    acc && !hit_ctrl && !hit_stat |-> PSLVERR && PREADY)
    else $error("unmapped access without error");

  c_fail_in_normal: cover property (@(posedge CLOCK) disable iff (!RST_N)
    in_normal && FAIL_EVT ##1 fail_r);
  c_restart_to_normal: cover property (@(posedge CLOCK) disable iff (!RST_N)
    (SBC_MODE == fogp_pkg::MODE_RESTART) ##1 in_normal && fail_r);
  c_strap_dev: cover property (@(posedge CLOCK) disable iff (!RST_N)
    $rose(DEV_MODE_STRAP));
  c_duty_change: cover property (@(posedge CLOCK) disable iff (!RST_N)
    wr_ctrl ##1 (duty_r == 2'h3));

endmodule
`default_nettype wire

// ==== rtl/fogp_pkg.sv ====
// Shared constants and types for the fail-output and GPIO pin control block.
// Assumes a 100 MHz core clock and an SBC mode code supplied by the state machine.
package fogp_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // Strap filter, a least time: round up
  localparam int STRAP_FILT_NS = 64000;
  localparam int STRAP_CYCLES  = (STRAP_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Indicator 1.25 Hz at 50 %: half period of 400 ms
  localparam int IND_HALF_NS   = 400000000;
  localparam int IND_CYCLES    = IND_HALF_NS / CLK_PERIOD_NS;

  // Pulsed light 100 Hz: period of 10 ms
  localparam int PL_PERIOD_NS  = 10000000;
  localparam int PL_CYCLES     = PL_PERIOD_NS / CLK_PERIOD_NS;

  localparam int CNT_W         = 26;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;

  // Control register field positions
  localparam int CTRL_F2_LSB   = 0;
  localparam int CTRL_F3_LSB   = 4;
  localparam int CTRL_SW2_BIT  = 8;
  localparam int CTRL_SW3_BIT  = 9;
  localparam int CTRL_DC_LSB   = 12;
  localparam int CTRL_FOON_BIT = 16;

  // Status register field positions
  localparam int STAT_FAIL_BIT = 0;
  localparam int STAT_FOON_BIT = 1;
  localparam int STAT_DEV_BIT  = 2;
  localparam int STAT_LVL2_BIT = 3;
  localparam int STAT_LVL3_BIT = 4;
  localparam int STAT_MODE_LSB = 8;

  localparam logic [1:0] DUTY_RST = 2'h0;

  typedef enum logic [2:0] {
    MODE_INIT, MODE_NORMAL, MODE_STOP, MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE
  } fogp_mode_t;

  typedef enum logic [2:0] {
    FUNC_FAIL, FUNC_OFF, FUNC_WAKE, FUNC_LOW, FUNC_HIGH
  } fogp_func_t;

  localparam fogp_func_t FUNC_RST = FUNC_FAIL;

  typedef struct packed {
    fogp_func_t func;
    logic       sw_on;
  } fogp_pincfg_t;

  typedef struct packed {
    logic o;
    logic oe;
    logic wake_en;
  } fogp_drv_t;

  // Active-low portion of one pulsed-light period: 20, 10, 5 or 2.5 %
  function automatic int fogp_duty_cycles(input logic [1:0] sel, input int period);
    unique case (sel)
      2'h0: return period / 5;
      2'h1: return period / 10;
      2'h2: return period / 20;
      2'h3: return period / 40;
    endcase
  endfunction

endpackage

// ==== rtl/fogp_pin_ctl.sv ====
// One alternate-function pin: resolves function and SBC mode into drive and wake enable.
// Assumes fail_wave already carries the failure state and waveform for this pin.
`timescale 1ns/1ns
`default_nettype none
module fogp_pin_ctl
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire fogp_pkg::fogp_mode_t mode,
  input  wire fogp_pkg::fogp_pincfg_t cfg,
  input  wire logic                 fail_wave,
  output fogp_pkg::fogp_drv_t       drv_r
);

  fogp_pkg::fogp_drv_t drv_nxt;
  wire logic           sw_run;
  wire logic           wake_ok;

  // Switches stay put in Stop/Sleep but drop in Restart, Fail-Safe and Init
  assign sw_run  = cfg.sw_on && (mode inside {fogp_pkg::MODE_NORMAL, fogp_pkg::MODE_STOP,
                                               fogp_pkg::MODE_SLEEP});
  assign wake_ok = mode inside {fogp_pkg::MODE_NORMAL, fogp_pkg::MODE_STOP,
                                fogp_pkg::MODE_SLEEP, fogp_pkg::MODE_RESTART};

  always_comb
  begin
    drv_nxt = '0;
    unique case (cfg.func)
      fogp_pkg::FUNC_FAIL: drv_nxt.oe = fail_wave;
      fogp_pkg::FUNC_OFF:  drv_nxt = '0;
      fogp_pkg::FUNC_WAKE: drv_nxt.wake_en = wake_ok;
      fogp_pkg::FUNC_LOW:  drv_nxt.oe = sw_run;
      fogp_pkg::FUNC_HIGH:
      begin
        drv_nxt.o  = 1'b1;
        drv_nxt.oe = sw_run;
      end
      default: drv_nxt = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      drv_r <= '0;
    else
      drv_r <= drv_nxt;
  end

  a_switch_off_restart: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.func inside {fogp_pkg::FUNC_LOW, fogp_pkg::FUNC_HIGH}) &&
    (mode inside {fogp_pkg::MODE_RESTART, fogp_pkg::MODE_FAILSAFE}) |=> !drv_r.oe)
    else $error("switch driven during restart or fail-safe");
  a_switch_resume: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.func == fogp_pkg::FUNC_LOW) && cfg.sw_on && (mode == fogp_pkg::MODE_NORMAL) &&
    ($past(mode) == fogp_pkg::MODE_RESTART) |=> drv_r.oe && !drv_r.o)
    else $error("low-side switch not resumed after restart");
  a_wake_failsafe_off: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == fogp_pkg::MODE_FAILSAFE) |=> !drv_r.wake_en)
    else $error("wake enabled in fail-safe");
  a_wake_kept_restart: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.func == fogp_pkg::FUNC_WAKE) &&
    (mode inside {fogp_pkg::MODE_STOP, fogp_pkg::MODE_SLEEP, fogp_pkg::MODE_RESTART})
    |=> drv_r.wake_en && !drv_r.oe)
    else $error("wake input lost capability");
  a_wake_resume: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.func == fogp_pkg::FUNC_WAKE) && (mode == fogp_pkg::MODE_NORMAL) &&
    ($past(mode) == fogp_pkg::MODE_RESTART) |=> drv_r.wake_en)
    else $error("wake not resumed after restart");
  a_off_pin_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.func == fogp_pkg::FUNC_OFF) |=> !drv_r.oe && !drv_r.wake_en)
    else $error("switched-off pin active");

endmodule
`default_nettype wire

// ==== sim/fogp_far_model.sv ====
// Far side of the two alternate-function pins: lamps or loads with pull-ups.
// Assumes the bench sinks the pulsed/strap pin on purpose for the strap filter.
`timescale 1ns/1ns
`default_nettype none
module fogp_far_model
(
  input  wire logic ind_o,
  input  wire logic ind_oe,
  input  wire logic pl_o,
  input  wire logic pl_oe,
  input  wire logic ext_pl_low,
  output logic      ind_pin,
  output logic      pl_pin
);
  // Released lines float to the pull-up, never to a stale value
  assign ind_pin = !(ind_oe && !ind_o);
  // Pull-up holds the strap pin high unless the bench or the pin drive sinks it
  assign pl_pin  = !((pl_oe && !pl_o) || ext_pl_low);
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the fail-output and pin control block over APB.
// Assumes shortened counter parameters; far model supplies pin levels.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int IND = 10;
  localparam int PL  = 80;
  logic                 CLOCK, RST_N, PSEL, PENABLE, PWRITE, FAIL_EVT, FAIL_COND, ext3;
  logic [7:0]           PADDR;
  logic [31:0]          PWDATA, PRDATA, rd;
  logic                 PREADY, PSLVERR, err, p2, p3;
  logic                 s_o, s_oe, i_o, i_oe, i_wk, l_o, l_oe, l_wk, dev;
  fogp_pkg::fogp_mode_t SBC_MODE;
  int                   bad_count = 0, cmp_count = 0, cyc = 0, hi, lo;

  fogp_fail_gpio #(.STRAP_CYCLES(8), .IND_CYCLES(IND), .PL_CYCLES(PL)) dut_u
  (
    .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SBC_MODE(SBC_MODE), .FAIL_EVT(FAIL_EVT), .FAIL_COND(FAIL_COND),
    .STATIC_FAIL_OUT_O(s_o), .STATIC_FAIL_OUT_OE(s_oe),
    .INDICATOR_FAIL_OUT_I(p2), .INDICATOR_FAIL_OUT_O(i_o), .INDICATOR_FAIL_OUT_OE(i_oe),
    .INDICATOR_WAKE_EN(i_wk), .PULSED_FAIL_OUT_STRAP_I(p3), .PULSED_FAIL_OUT_STRAP_O(l_o),
    .PULSED_FAIL_OUT_STRAP_OE(l_oe), .PULSED_WAKE_EN(l_wk), .DEV_MODE_STRAP(dev)
  );
  fogp_far_model far_u
  (
    .ind_o(i_o), .ind_oe(i_oe), .pl_o(l_o), .pl_oe(l_oe), .ext_pl_low(ext3),
    .ind_pin(p2), .pl_pin(p3)
  );

  initial
  begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end

  task automatic summarize;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Run is about a thousand cycles; the ceiling leaves wide margin
  always @(posedge CLOCK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      $display("ERROR t=%0t timeout", $time);
      summarize;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask

  task automatic tick;
    @(posedge CLOCK);
    #1;
  endtask

  // Read data and error are taken at the edge where pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    @(posedge CLOCK);
    while (PREADY !== 1'b1)
      @(posedge CLOCK);
    err = PSLVERR;
    rd = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic go(input fogp_pkg::fogp_mode_t m);
    @(posedge CLOCK);
    SBC_MODE <= m;
    repeat (3) tick;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return i_oe;
      1: return l_oe;
      2: return dev;
      default: return s_oe;
    endcase
  endfunction

  task automatic wait_lvl(input int s, input logic v);
    int n;
    n = 0;
    while (pick(s) !== v && n < 400)
    begin
      tick;
      n++;
    end
  endtask

  // Skips any partial period, then counts one full high and low phase
  task automatic meas(input int s);
    wait_lvl(s, 1'b0);
    wait_lvl(s, 1'b1);
    hi = 0;
    lo = 0;
    while (pick(s) === 1'b1 && hi < 400)
    begin
      tick;
      hi++;
    end
    while (pick(s) === 1'b0 && lo < 400)
    begin
      tick;
      lo++;
    end
  endtask

  task automatic fail_in(input fogp_pkg::fogp_mode_t m);
    @(posedge CLOCK);
    FAIL_EVT <= 1'b1;
    SBC_MODE <= m;
    @(posedge CLOCK);
    FAIL_EVT <= 1'b0;
    wait_lvl(3, 1'b1);
  endtask

  task automatic clear_fail;
    go(fogp_pkg::MODE_NORMAL);
    wr(fogp_pkg::STAT_OFS, 32'h0000_0001);
    repeat (3) tick;
  endtask

  task automatic t_reset;
    repeat (2) tick;
    chk(32'({s_oe, i_oe, l_oe, i_wk, l_wk, dev}), 32'h0);
    rdc(fogp_pkg::CTRL_OFS, 32'h0000_0000);
    $display("t_reset done");
  endtask

  task automatic t_strap;
    @(posedge CLOCK);
    ext3 <= 1'b1;
    repeat (5) @(posedge CLOCK);
    ext3 <= 1'b0;
    repeat (20) tick;
    chk1(dev, 1'b0);
    @(posedge CLOCK);
    ext3 <= 1'b1;
    repeat (6) tick;
    chk1(dev, 1'b0);
    wait_lvl(2, 1'b1);
    chk1(dev, 1'b1);
    apb(1'b0, fogp_pkg::STAT_OFS, 32'h0);
    chk1(rd[2], 1'b1);
    @(posedge CLOCK);
    ext3 <= 1'b0;
    repeat (20) tick;
    chk1(dev, 1'b0);
    $display("t_strap done");
  endtask

  task automatic t_fail;
    go(fogp_pkg::MODE_NORMAL);
    @(posedge CLOCK);
    FAIL_COND <= 1'b1;
    fail_in(fogp_pkg::MODE_RESTART);
    chk(32'({s_oe, i_oe, l_oe, s_o}), 32'hE);
    meas(0);
    chk(hi, IND);
    chk(lo, IND);
    meas(1);
    chk(hi, PL / 5);
    chk(lo, PL - PL / 5);
    go(fogp_pkg::MODE_NORMAL);
    chk1(s_oe, 1'b1);
    rdc(fogp_pkg::CTRL_OFS, 32'h0000_0000);
    go(fogp_pkg::MODE_FAILSAFE);
    chk1(s_oe, 1'b1);
    clear_fail;
    chk1(s_oe, 1'b1);
    @(posedge CLOCK);
    FAIL_COND <= 1'b0;
    clear_fail;
    chk1(s_oe, 1'b0);
    $display("t_fail done");
  endtask

  task automatic t_duty;
    int dv[4] = '{5, 10, 20, 40};
    for (int d = 0; d < 4; d++)
    begin
      wr(fogp_pkg::CTRL_OFS, 32'h0001_0000 | (32'(d) << 12));
      meas(1);
      chk(hi, PL / dv[d]);
      chk(hi + lo, PL);
    end
    wr(fogp_pkg::CTRL_OFS, 32'h0000_0000);
    $display("t_duty done");
  endtask

  task automatic t_gpio;
    fogp_pkg::fogp_mode_t ms[6];
    logic                 wk[6] = '{1, 1, 1, 1, 1, 0};
    logic                 oe[6] = '{1, 1, 1, 0, 1, 0};
    ms = '{fogp_pkg::MODE_NORMAL, fogp_pkg::MODE_STOP, fogp_pkg::MODE_SLEEP,
           fogp_pkg::MODE_RESTART, fogp_pkg::MODE_NORMAL, fogp_pkg::MODE_FAILSAFE};
    // Pin 2 wake input, pin 3 low-side switch on
    wr(fogp_pkg::CTRL_OFS, 32'h0000_0232);
    rdc(fogp_pkg::CTRL_OFS, 32'h0000_0232);
    for (int i = 0; i < 6; i++)
    begin
      go(ms[i]);
      chk1(i_wk, wk[i]);
      chk1(l_oe, oe[i]);
      if (i == 1)
      begin
        wr(fogp_pkg::CTRL_OFS, 32'h0000_0241);
        rdc(fogp_pkg::CTRL_OFS, 32'h0000_0232);
        chk1(l_oe, 1'b1);
      end
    end
    go(fogp_pkg::MODE_NORMAL);
    chk1(l_o, 1'b0);
    rdc(fogp_pkg::CTRL_OFS, 32'h0000_0232);
    $display("t_gpio done");
  endtask

  task automatic t_off;
    // Pin 2 off, pin 3 high-side switch on
    wr(fogp_pkg::CTRL_OFS, 32'h0000_0241);
    repeat (3) tick;
    chk(32'({l_oe, l_o}), 32'h3);
    fail_in(fogp_pkg::MODE_RESTART);
    chk1(s_oe, 1'b1);
    chk1(l_oe, 1'b0);
    hi = 0;
    repeat (25)
    begin
      tick;
      hi += int'(i_oe !== 1'b0 || i_wk !== 1'b0);
    end
    chk(hi, 0);
    go(fogp_pkg::MODE_FAILSAFE);
    chk(32'({i_oe, l_oe}), 32'h0);
    clear_fail;
    chk1(s_oe, 1'b0);
    $display("t_off done");
  endtask

  task automatic t_bus;
    apb(1'b0, 8'h10, 32'h0);
    chk1(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h20, 32'hFFFF_FFFF);
    chk1(err, 1'b1);
    rdc(fogp_pkg::CTRL_OFS, 32'h0000_0241);
    $display("t_bus done");
  endtask

  initial
  begin
    RST_N = 1'b0;
    {PSEL, PENABLE, PWRITE, FAIL_EVT, FAIL_COND, ext3} = 6'h00;
    PADDR = 8'h00;
    PWDATA = 32'h0000_0000;
    SBC_MODE = fogp_pkg::MODE_INIT;
    repeat (20) @(posedge CLOCK);
    RST_N <= 1'b1;
    t_reset;
    t_strap;
    t_fail;
    t_duty;
    t_gpio;
    t_off;
    t_bus;
    summarize;
  end
endmodule
`default_nettype wire
